// [shared/serial_port_pkg.sv]
// shared constants and types for the serial port control block
package serial_port_pkg;

    localparam logic [4:0]  ADDR_CTRL_ONE = 5'h00;
    localparam logic [4:0]  ADDR_CTRL_TWO = 5'h04;
    localparam logic [4:0]  ADDR_STATUS   = 5'h08;
    localparam logic [4:0]  ADDR_DATA     = 5'h0C;
    localparam logic [4:0]  ADDR_DIVISOR  = 5'h10;

    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] DIVISOR_RESET = 16'h0010;
    localparam logic [3:0]  LEN_SHORT     = 4'hA;
    localparam logic [3:0]  LEN_LONG      = 4'hB;
    localparam logic [10:0] FRAME_ONES    = 11'h7FF;
    localparam logic [10:0] FRAME_ZEROS   = 11'h000;

    typedef struct packed {
        logic loopback_sel;
        logic port_on;
        logic tx_invert;
        logic long_char;
        logic wake_addr;
        logic idle_count_start;
        logic parity_on;
        logic parity_odd_sel;
    } ctrl_one_t;

    typedef struct packed {
        logic txempty_irq_en;
        logic txdone_irq_en;
        logic rxfull_irq_en;
        logic quiet_irq_en;
        logic tx_enable;
        logic rx_enable;
        logic rx_standby;
        logic break_send;
    } ctrl_two_t;

    typedef struct packed {
        logic overrun;
        logic frame_err;
        logic parity_err;
        logic quiet;
        logic rx_full_flag;
        logic tx_done_flag;
        logic tx_empty_flag;
    } status_t;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_t;

    typedef enum logic [0:0] {
        RX_IDLE  = 1'b0,
        RX_FRAME = 1'b1
    } rx_state_t;

endpackage : serial_port_pkg

// [rtl/async_serial_port_control.sv]
// serial port control, transmitter and receiver behind an avalon-mm slave
//
// Summary of operation
// - port enabled: transmit pin driven as output, direction bit ignored.
// - port enabled: receive pin is receiver input, direction bit ignored.
// - loopback cuts the receive pin, transmitter feeds receiver; software enables both.
// - port enable gates port and baud timer; clearing sets empty, done, masks tx requests.
// - inversion flips every transmitted level, idle, break, start and stop included.
// - short select gives 10-bit characters, long select gives 11-bit characters.
// - parity bit replaces the top data bit; total length unchanged.
// - parity select 1 odd, 0 even; software leaves it alone mid-character.
// - wakeup select 1 means address mark in top bit, 0 means idle line.
// - idle count starts after stop bit when set, after start bit when clear.
// - empty and done flags each raise the tx request under their own enable.
// - full and idle flags each raise the rx request under their own enable.
// - rising transmit enable sends a preamble of 10 or 11 ones.
// - dropping transmit enable finishes the current character, then idles high.
// - transmit enable cleared and set mid-character queues one idle character.
// - clearing receive enable stops the receiver, flags left as they are.
// - standby masks rx requests; selected wakeup clears standby in hardware.
// - one break pulse then a one; held break gives back-to-back breaks.
// - break pending before the preamble replaces it; software avoids this.
// - reset clears both control registers entirely.
// - address wakeup clears standby and sets full; idle wakeup sets no flag.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_control
    import serial_port_pkg::*;
#(
    parameter logic [15:0] DIVISOR_DEFAULT = DIVISOR_RESET
) (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        rx_line_pin_in,
    input  wire logic        port_e_dir_bit_zero_in,
    input  wire logic        port_e_dir_bit_one_in,
    input  wire logic        gpio_tx_level_in,
    input  wire logic        gpio_rx_level_in,
    output logic             tx_line_pin_out,
    output logic             tx_line_pin_oe_out,
    output logic             rx_line_pin_out,
    output logic             rx_line_pin_oe_out,
    output logic             tx_irq_out,
    output logic             rx_irq_out
);

    typedef struct packed {
        ctrl_one_t   c1;
        ctrl_two_t   c2;
        logic [15:0] divisor;
        logic        ack;
        logic [31:0] rdata;
        tx_state_t   txs;
        logic [10:0] tx_sh;
        logic [3:0]  tx_left;
        logic [15:0] tx_cnt;
        logic        tx_line;
        logic [8:0]  tx_buf;
        logic        tx_empty;
        logic        pre_pend;
        logic        brk_frame;
        logic        rx_s1;
        logic        rx_s2;
        rx_state_t   rxs;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_left;
        logic [10:0] rx_sh;
        logic [8:0]  rx_data;
        logic        rx_full;
        logic        quiet;
        logic        par_err;
        logic        frm_err;
        logic        ovr;
        logic [3:0]  ones;
        logic        quiet_armed;
        logic        arm_rx;
    } st_t;

    st_t st;
    st_t next_st;

    function automatic logic [3:0] frame_len(input logic long_c);
        return long_c ? LEN_LONG : LEN_SHORT;
    endfunction : frame_len

    function automatic logic [15:0] reload(input logic [15:0] d);
        return (d == 16'h0000) ? 16'h0000 : d - 16'h0001;
    endfunction : reload

    function automatic logic [10:0] make_frame(input logic [8:0] d,
                                               input ctrl_one_t c);
        logic [8:0] v;
        v = d;
        if (c.parity_on) begin
            if (c.long_char) begin
                v[8] = (^d[7:0]) ^ c.parity_odd_sel;
            end else begin
                v[7] = (^d[6:0]) ^ c.parity_odd_sel;
            end
        end
        // lsb first: start in bit 0, stop on top
        if (c.long_char) begin
            return {1'b1, v, 1'b0};
        end
        return {2'b11, v[7:0], 1'b0};
    endfunction : make_frame

    logic      bus_req;
    logic      wr_hit;
    logic      rd_hit;
    logic      tx_done_now;
    logic      tx_tick;
    logic      rx_tick;
    logic      rx_src;
    logic      rx_on;
    logic      can_start;
    logic      quiet_ev;
    logic      char_ev;
    logic      start_now;
    logic [10:0] sh_n;
    logic [8:0]  rx_word;
    logic        rx_msb;
    logic        rx_par_bad;
    logic [3:0]  ones_n;
    status_t     stat;
    ctrl_two_t   c2_w;

    assign bus_req = avs_read_in | avs_write_in;
    assign wr_hit  = avs_write_in & st.ack;
    assign rd_hit  = avs_read_in & st.ack;

    // one wait state per access, then the request completes
    assign avs_waitrequest_out = bus_req & ~st.ack;
    assign avs_readdata_out    = st.rdata;

    assign tx_done_now = st.tx_empty & (st.txs == TX_IDLE)
                         & ~st.pre_pend;
    assign stat = '{overrun:       st.ovr,
                    frame_err:     st.frm_err,
                    parity_err:    st.par_err,
                    quiet:         st.quiet,
                    rx_full_flag:  st.rx_full,
                    tx_done_flag:  tx_done_now,
                    tx_empty_flag: st.tx_empty};

    // transmitter requests vanish while the port is off
    assign tx_irq_out = st.c1.port_on
        & ((st.tx_empty & st.c2.txempty_irq_en)
        | (tx_done_now & st.c2.txdone_irq_en));
    // standby hides receiver requests
    assign rx_irq_out = ~st.c2.rx_standby
        & ((st.rx_full & st.c2.rxfull_irq_en)
        | (st.quiet & st.c2.quiet_irq_en));

    // pin takeover: port owns both pins while enabled
    assign tx_line_pin_oe_out = st.c1.port_on | port_e_dir_bit_zero_in;
    assign tx_line_pin_out    = st.c1.port_on
        ? (st.tx_line ^ st.c1.tx_invert) : gpio_tx_level_in;
    assign rx_line_pin_oe_out = ~st.c1.port_on & port_e_dir_bit_one_in;
    assign rx_line_pin_out    = gpio_rx_level_in;

    // loopback uses the uninverted line so the receiver still frames
    assign rx_src = st.c1.loopback_sel ? st.tx_line : st.rx_s2;
    assign rx_on  = st.c1.port_on & st.c2.rx_enable;

    assign tx_tick = st.c1.port_on & (st.tx_cnt == 16'h0000);
    assign rx_tick = rx_on & (st.rx_cnt == 16'h0000);

    // a finished break holds the line high one bit unless break is held
    assign can_start = st.c1.port_on & st.c2.tx_enable & tx_tick
        & ((st.txs == TX_IDLE)
        | ((st.tx_left == 4'h1)
        & (~st.brk_frame | st.c2.break_send)));

    assign start_now = can_start
        & (st.c2.break_send | st.pre_pend | ~st.tx_empty);

    assign sh_n    = {rx_src, st.rx_sh[10:1]};
    assign rx_word = st.c1.long_char ? sh_n[9:1]
                                     : {1'b0, sh_n[9:2]};
    assign rx_msb  = st.c1.long_char ? rx_word[8] : rx_word[7];
    assign rx_par_bad = st.c1.parity_on
        & ((^rx_word) != st.c1.parity_odd_sel);

    assign ones_n = (st.ones == frame_len(st.c1.long_char))
        ? st.ones : st.ones + 4'h1;

    assign char_ev = (st.rxs == RX_FRAME) & rx_tick
        & (st.rx_left == 4'h1);

    // idle reached when the count of ones first hits a full character
    assign quiet_ev = rx_tick & rx_src
        & (st.ones == frame_len(st.c1.long_char) - 4'h1)
        & ~((st.rxs == RX_FRAME) & (st.rx_left
        == frame_len(st.c1.long_char)));

    assign c2_w = ctrl_two_t'(avs_writedata_in[7:0]);

    always_comb begin
        next_st = st;
        next_st.rx_s1 = rx_line_pin_in;
        next_st.rx_s2 = st.rx_s1;

        // bus slave
        next_st.ack = bus_req & ~st.ack;
        if (avs_read_in & ~st.ack) begin
            case (avs_address_in)
                ADDR_CTRL_ONE: next_st.rdata = {24'h00_0000, st.c1};
                ADDR_CTRL_TWO: next_st.rdata = {24'h00_0000, st.c2};
                ADDR_STATUS:   next_st.rdata = {25'h000_0000, stat};
                ADDR_DATA:     next_st.rdata = {23'h00_0000, st.rx_data};
                ADDR_DIVISOR:  next_st.rdata = {16'h0000, st.divisor};
                default:       next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (rd_hit && avs_address_in == ADDR_STATUS) begin
            next_st.arm_rx = st.rx_full | st.quiet;
        end
        if (rd_hit && avs_address_in == ADDR_DATA && st.arm_rx) begin
            next_st.rx_full = 1'b0;
            next_st.quiet   = 1'b0;
            next_st.par_err = 1'b0;
            next_st.frm_err = 1'b0;
            next_st.ovr     = 1'b0;
            next_st.arm_rx  = 1'b0;
        end
        if (wr_hit) begin
            case (avs_address_in)
                ADDR_CTRL_ONE: begin
                    next_st.c1 = ctrl_one_t'(avs_writedata_in[7:0]);
                end
                ADDR_CTRL_TWO: begin
                    next_st.c2 = c2_w;
                    // a rising enable, even mid-character, queues ones
                    if (c2_w.tx_enable && !st.c2.tx_enable) begin
                        next_st.pre_pend = 1'b1;
                    end
                end
                ADDR_DATA: begin
                    next_st.tx_buf   = avs_writedata_in[8:0];
                    next_st.tx_empty = 1'b0;
                end
                ADDR_DIVISOR: next_st.divisor = avs_writedata_in[15:0];
                default: begin
                end
            endcase
        end

        // transmitter
        if (st.c1.port_on) begin
            next_st.tx_cnt = tx_tick ? reload(st.divisor)
                                     : st.tx_cnt - 16'h0001;
        end else begin
            next_st.tx_cnt = reload(st.divisor);
        end
        if (tx_tick && st.txs == TX_SHIFT) begin
            next_st.tx_sh   = {1'b1, st.tx_sh[10:1]};
            next_st.tx_line = st.tx_sh[1];
            next_st.tx_left = st.tx_left - 4'h1;
            if (st.tx_left == 4'h1) begin
                next_st.txs       = TX_IDLE;
                next_st.tx_line   = 1'b1;
                next_st.brk_frame = 1'b0;
            end
        end
        if (start_now) begin
            next_st.txs     = TX_SHIFT;
            next_st.tx_left = frame_len(st.c1.long_char);
            if (st.c2.break_send) begin
                // break wins over a pending preamble
                next_st.tx_sh     = FRAME_ZEROS;
                next_st.brk_frame = 1'b1;
                next_st.pre_pend  = 1'b0;
            end else if (st.pre_pend) begin
                next_st.tx_sh     = FRAME_ONES;
                next_st.brk_frame = 1'b0;
                next_st.pre_pend  = 1'b0;
            end else begin
                next_st.tx_sh     = make_frame(st.tx_buf, st.c1);
                next_st.brk_frame = 1'b0;
                next_st.tx_empty  = 1'b1;
            end
            next_st.tx_line = next_st.tx_sh[0];
        end
        if (!st.c1.port_on) begin
            next_st.txs       = TX_IDLE;
            next_st.tx_line   = 1'b1;
            next_st.tx_empty  = 1'b1;
            next_st.pre_pend  = 1'b0;
            next_st.brk_frame = 1'b0;
        end

        // receiver
        if (rx_on) begin
            next_st.rx_cnt = rx_tick ? reload(st.divisor)
                                     : st.rx_cnt - 16'h0001;
            if (st.rxs == RX_IDLE) begin
                if (!rx_src) begin
                    // centre the samples on each bit
                    next_st.rxs     = RX_FRAME;
                    next_st.rx_cnt  = {1'b0, st.divisor[15:1]};
                    next_st.rx_left = frame_len(st.c1.long_char);
                    next_st.ones    = 4'h0;
                end else if (rx_tick) begin
                    next_st.ones = ones_n;
                end
            end else if (rx_tick) begin
                next_st.rx_sh   = sh_n;
                next_st.rx_left = st.rx_left - 4'h1;
                if (st.rx_left != frame_len(st.c1.long_char)) begin
                    // start bit itself never counts
                    next_st.ones = rx_src ? ones_n : 4'h0;
                end
                if (st.rx_left == 4'h1) begin
                    next_st.rxs = RX_IDLE;
                    if (st.c1.idle_count_start) begin
                        next_st.ones = 4'h0;
                    end
                end
            end
        end else begin
            // flags deliberately untouched
            next_st.rxs    = RX_IDLE;
            next_st.rx_cnt = reload(st.divisor);
            next_st.ones   = 4'h0;
        end

        // hardware events last so a set beats a same-cycle clear
        if (quiet_ev) begin
            if (st.c2.rx_standby && !st.c1.wake_addr) begin
                next_st.c2.rx_standby = 1'b0;
            end else if (!st.c2.rx_standby && st.quiet_armed) begin
                next_st.quiet       = 1'b1;
                next_st.quiet_armed = 1'b0;
            end
        end
        if (char_ev) begin
            if (st.c2.rx_standby) begin
                if (st.c1.wake_addr && rx_msb) begin
                    next_st.c2.rx_standby = 1'b0;
                    next_st.rx_data       = rx_word;
                    next_st.rx_full       = 1'b1;
                end
            end else begin
                if (st.rx_full) begin
                    next_st.ovr = 1'b1;
                end else begin
                    next_st.rx_data = rx_word;
                end
                next_st.rx_full     = 1'b1;
                next_st.quiet_armed = 1'b1;
                next_st.par_err     = st.par_err | rx_par_bad;
                next_st.frm_err     = st.frm_err | ~sh_n[10];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st          <= '0;
            st.c1       <= ctrl_one_t'(CTRL_RESET);
            st.c2       <= ctrl_two_t'(CTRL_RESET);
            st.divisor  <= DIVISOR_DEFAULT;
            st.tx_line  <= 1'b1;
            st.tx_empty <= 1'b1;
            st.rx_s1    <= 1'b1;
            st.rx_s2    <= 1'b1;
            st.txs      <= TX_IDLE;
            st.rxs      <= RX_IDLE;
        end else begin
            st <= next_st;
        end
    end

endmodule : async_serial_port_control
`default_nettype wire

// [tb/serial_port_assertions.sv]
// assertion checker on the serial port control block ports
`timescale 1ns/1ns
`default_nettype none
module serial_port_checker
    import serial_port_pkg::*;
#(
    parameter logic [15:0] DIVISOR_DEFAULT = DIVISOR_RESET
) (
    input wire logic        mclk_in,
    input wire logic        srst_in,
    input wire logic [4:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic        avs_waitrequest_out,
    input wire logic        port_e_dir_bit_zero_in,
    input wire logic        gpio_tx_level_in,
    input wire logic        tx_line_pin_out,
    input wire logic        tx_line_pin_oe_out,
    input wire logic        rx_line_pin_oe_out,
    input wire logic        tx_irq_out,
    input wire logic        rx_irq_out
);
    ctrl_one_t one_q;
    ctrl_two_t two_q;
    logic      wr_done;
    assign wr_done = avs_write_in && !avs_waitrequest_out;
    // shadow copy, taken at the edge where a write completes
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            one_q <= CTRL_RESET;
            two_q <= CTRL_RESET;
        end else begin
            if (wr_done && avs_address_in == ADDR_CTRL_ONE) one_q <= avs_writedata_in[7:0];
            if (wr_done && avs_address_in == ADDR_CTRL_TWO) two_q <= avs_writedata_in[7:0];
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    property p_one_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    property p_first_wait;
        $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out;
    endproperty
    property p_tx_drive;
        one_q.port_on |-> tx_line_pin_oe_out;
    endproperty
    property p_rx_input;
        one_q.port_on |-> !rx_line_pin_oe_out;
    endproperty
    property p_port_off;
        !one_q.port_on [*2] |-> tx_line_pin_out == gpio_tx_level_in && !tx_irq_out
            && tx_line_pin_oe_out == port_e_dir_bit_zero_in;
    endproperty
    property p_tx_mask;
        !two_q.txempty_irq_en && !two_q.txdone_irq_en |-> !tx_irq_out;
    endproperty
    property p_rx_mask;
        !two_q.rxfull_irq_en && !two_q.quiet_irq_en |-> !rx_irq_out;
    endproperty
    property p_reset;
        $fell(srst_in) |-> !tx_irq_out && !rx_irq_out
            && tx_line_pin_oe_out == port_e_dir_bit_zero_in;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
    a_first_wait: assert property (p_first_wait) else $error("request not held off");
    a_tx_drive: assert property (p_tx_drive) else $error("tx pin not driven");
    a_rx_input: assert property (p_rx_input) else $error("rx pin driven");
    a_port_off: assert property (p_port_off) else $error("port off not gated");
    a_tx_mask: assert property (p_tx_mask) else $error("tx request unmasked");
    a_rx_mask: assert property (p_rx_mask) else $error("rx request unmasked");
    a_reset: assert property (p_reset) else $error("state after reset wrong");
    c_data: cover property (wr_done && avs_address_in == ADDR_DATA);
    c_tx_irq: cover property ($rose(tx_irq_out));
    c_rx_irq: cover property ($rose(rx_irq_out));
endmodule : serial_port_checker
`default_nettype wire

// [tb/remote_station.sv]
// remote serial station: drives the receive pin, captures the transmit pin
`timescale 1ns/1ns
`default_nettype none
module remote_station #(
    parameter int BIT = 4
) (
    input  wire logic mclk_in,
    input  wire logic line_in,
    output logic      line_out
);
    logic [10:0] cap;
    int          len;
    int          frames;
    initial begin
        line_out = 1'b1;
        len      = 10;
        frames   = 0;
        cap      = '0;
    end
    // bits go out index 0 first; caller packs start, data lsb first, stop
    task send(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (BIT) @(posedge mclk_in);
        end
        line_out <= 1'b1;
    endtask : send
    // mid-bit sampling; a held low line restarts capture at once
    always begin
        @(posedge mclk_in iff line_in === 1'b0);
        repeat (BIT / 2) @(posedge mclk_in);
        for (int i = 0; i < len; i++) begin
            if (i > 0) repeat (BIT) @(posedge mclk_in);
            cap[i] = line_in;
        end
        // leave the stop bit early so a back-to-back start is not missed
        repeat (BIT / 2) @(posedge mclk_in);
        frames++;
    end
endmodule : remote_station
`default_nettype wire

// [tb/async_serial_port_control_tb.sv]
// self-checking bench for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_control_tb
    import serial_port_pkg::*;
;
    localparam int BIT = 4;
    logic        mclk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [4:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    logic        rx_line_pin_in, port_e_dir_bit_zero_in, port_e_dir_bit_one_in;
    logic        gpio_tx_level_in, gpio_rx_level_in, tx_line_pin_out, tx_line_pin_oe_out;
    logic        rx_line_pin_out, rx_line_pin_oe_out, tx_irq_out, rx_irq_out;
    int          error_cnt = 0;
    int          comparisons = 0;
    async_serial_port_control #(.DIVISOR_DEFAULT(16'h0004)) i_dut (.mclk_in, .srst_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .rx_line_pin_in, .port_e_dir_bit_zero_in,
        .port_e_dir_bit_one_in, .gpio_tx_level_in, .gpio_rx_level_in, .tx_line_pin_out,
        .tx_line_pin_oe_out, .rx_line_pin_out, .rx_line_pin_oe_out, .tx_irq_out,
        .rx_irq_out);
    remote_station #(.BIT(BIT)) i_remote (.mclk_in, .line_in(tx_line_pin_out),
        .line_out(rx_line_pin_in));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one avalon transfer; held until waitrequest is sampled low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        @(posedge mclk_in);
        // no cycle count assumed: only the watchdog ends a stuck wait
        while (avs_waitrequest_out !== 1'b0) @(posedge mclk_in);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask : bus
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rd_chk
    task wait_frames(input int n);
        for (int k = 0; k < 400 && i_remote.frames < n; k++) @(posedge mclk_in);
    endtask : wait_frames
    task finish_test;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // whole run is several hundred cycles
    initial begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        finish_test;
    end
    initial begin
        {srst_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
        srst_in                = 1'b1;
        port_e_dir_bit_zero_in = 1'b0;
        port_e_dir_bit_one_in  = 1'b1;
        gpio_tx_level_in       = 1'b1;
        gpio_rx_level_in       = 1'b0;
        repeat (16) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd_chk(ADDR_CTRL_ONE, 32'h0000_0000, "ctrl one");
        rd_chk(ADDR_CTRL_TWO, 32'h0000_0000, "ctrl two");
        rd_chk(ADDR_STATUS, 32'h0000_0003, "status");
        rd_chk(5'h14, 32'h0000_0000, "unmapped");
        rd_chk(ADDR_DIVISOR, 32'h0000_0004, "divisor");
        check("pins off", 32'({tx_line_pin_oe_out, tx_line_pin_out, rx_line_pin_oe_out,
            rx_line_pin_out}), 32'h0000_0006);
        wr(ADDR_CTRL_ONE, 32'h0000_0040);
        @(negedge mclk_in);
        check("tx oe", 32'(tx_line_pin_oe_out), 32'h0000_0001);
        check("rx oe", 32'(rx_line_pin_oe_out), 32'h0000_0000);
        wr(ADDR_CTRL_TWO, 32'h0000_008C);
        @(negedge mclk_in);
        check("tx irq", 32'(tx_irq_out), 32'h0000_0001);
        repeat (13 * BIT) @(posedge mclk_in);
        check("preamble", i_remote.frames, 0);
        wr(ADDR_DATA, 32'h0000_00A5);
        wait_frames(1);
        check("short frame", 32'(i_remote.cap[9:0]), 32'({1'b1, 8'hA5, 1'b0}));
        wr(ADDR_CTRL_TWO, 32'h0000_000C);
        @(negedge mclk_in);
        check("tx irq masked", 32'(tx_irq_out), 32'h0000_0000);
        i_remote.len = 11;
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL_ONE, 32'h0000_0052 | k);
            wr(ADDR_DATA, 32'h0000_00FF);
            wait_frames(2 + k);
            check("parity frame", 32'(i_remote.cap), 32'({1'b1, k[0], 8'hFF, 1'b0}));
        end
        wr(ADDR_CTRL_ONE, 32'h0000_0040);
        i_remote.len = 10;
        wr(ADDR_CTRL_TWO, 32'h0000_002C);
        i_remote.send({1'b0, 1'b1, 8'h3C, 1'b0}, 10);
        repeat (BIT) @(posedge mclk_in);
        check("rx irq", 32'(rx_irq_out), 32'h0000_0001);
        wr(ADDR_CTRL_TWO, 32'h0000_0028);
        @(negedge mclk_in);
        check("rx irq kept", 32'(rx_irq_out), 32'h0000_0001);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("rx full", 32'(rd[2]), 32'h0000_0001);
        rd_chk(ADDR_DATA, 32'h0000_003C, "rx data");
        @(negedge mclk_in);
        check("rx irq cleared", 32'(rx_irq_out), 32'h0000_0000);
        wr(ADDR_CTRL_ONE, 32'h0000_0048);
        wr(ADDR_CTRL_TWO, 32'h0000_002E);
        i_remote.send({2'b01, 8'h85, 1'b0}, 10);
        repeat (BIT) @(posedge mclk_in);
        rd_chk(ADDR_CTRL_TWO, 32'h0000_002C, "standby woken");
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("wake full", 32'(rd[2]), 32'h0000_0001);
        rd_chk(ADDR_DATA, 32'h0000_0085, "wake data");
        wr(ADDR_CTRL_TWO, 32'h0000_000C);
        wr(ADDR_CTRL_ONE, 32'h0000_00C0);
        wr(ADDR_DATA, 32'h0000_005A);
        repeat (20 * BIT) @(posedge mclk_in);
        rd_chk(ADDR_DATA, 32'h0000_005A, "loopback data");
        wr(ADDR_CTRL_ONE, 32'h0000_0040);
        wr(ADDR_CTRL_TWO, 32'h0000_000D);
        repeat (2 * BIT) @(posedge mclk_in);
        wr(ADDR_CTRL_TWO, 32'h0000_000C);
        wait_frames(i_remote.frames + 1);
        check("break frame", 32'(i_remote.cap[9:0]), 32'h0000_0000);
        @(negedge mclk_in);
        check("after break", 32'(tx_line_pin_out), 32'h0000_0001);
        repeat (4 * BIT) @(posedge mclk_in);
        wr(ADDR_CTRL_ONE, 32'h0000_0060);
        @(negedge mclk_in);
        check("inverted idle", 32'(tx_line_pin_out), 32'h0000_0000);
        wr(ADDR_CTRL_TWO, 32'h0000_00CC);
        wr(ADDR_DATA, 32'h0000_0011);
        wr(ADDR_CTRL_ONE, 32'h0000_0000);
        @(negedge mclk_in);
        check("tx irq off", 32'(tx_irq_out), 32'h0000_0000);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("empty and done", 32'(rd[1:0]), 32'h0000_0003);
        finish_test;
    end
endmodule : async_serial_port_control_tb
bind async_serial_port_control serial_port_checker #(.DIVISOR_DEFAULT(DIVISOR_DEFAULT))
    i_chk (.mclk_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_waitrequest_out, .port_e_dir_bit_zero_in, .gpio_tx_level_in,
    .tx_line_pin_out, .tx_line_pin_oe_out, .rx_line_pin_oe_out, .tx_irq_out, .rx_irq_out);
`default_nettype wire
